// [common/diag_cfg_pkg.sv]
// constants for the bias fault-diagnostics configuration bank
// assumes an 8-bit register port with a 7-bit register address
package diag_cfg_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [6:0] PWRDN_OFFSET    = 7'h50;
	localparam logic [6:0] OV_SB_OFFSET    = 7'h51;
	localparam logic [6:0] IN_SB_OFFSET    = 7'h52;
	localparam logic [6:0] MON_EN_OFFSET   = 7'h53;
	localparam logic [6:0] FILT_OFFSET     = 7'h54;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] PWRDN_RESET     = 8'h88;
	localparam logic [7:0] OV_SB_RESET     = 8'h40;
	localparam logic [7:0] IN_SB_RESET     = 8'h44;
	localparam logic [7:0] MON_EN_RESET    = 8'h00;
	localparam logic [7:0] FILT_RESET      = 8'h48;

	// ----------------------------------------
	// field positions, power-down register
	// ----------------------------------------
	localparam int SHORT_BIT      = 7;
	localparam int OVERCUR_BIT    = 6;
	localparam int UNDERCUR_BIT   = 5;
	localparam int OVERVOLT_BIT   = 4;
	localparam int OVERTEMP_BIT   = 3;
	localparam int MANUAL_BIT     = 2;
	localparam int AUTO_BIT       = 1;
	localparam int SHORT_DIS_BIT  = 0;

	// ----------------------------------------
	// field positions and writable masks
	// ----------------------------------------
	localparam int OV_SB_LSB      = 5;
	localparam int PIN_BIAS_LSB   = 5;
	localparam int PIN_OV_LSB     = 2;
	localparam int FORCE_BIT      = 7;
	localparam int LOAD_BIT       = 6;
	localparam int BIAS_BIT       = 5;
	localparam int BATT_BIT       = 4;
	localparam int TEMP_BIT       = 3;
	localparam int AVDD_BIT       = 2;
	localparam int AUX_BIT        = 1;
	localparam logic [7:0] OV_SB_WMASK  = 8'hE0;
	localparam logic [7:0] IN_SB_WMASK  = 8'hFC;
	localparam logic [7:0] MON_EN_WMASK = 8'hFE;
	localparam logic [7:0] FILT_WMASK   = 8'h7F;

	// ----------------------------------------
	// recovery timing
	// ----------------------------------------
	localparam int         RECHECK_NS     = 1000;
	localparam int         CLK_NS         = 25;
	localparam logic [7:0] RECHECK_CYCLES = 8'(RECHECK_NS / CLK_NS);

	typedef enum logic [1:0] {
		ST_ON      = 2'b00,
		ST_OFF     = 2'b01,
		ST_RECHECK = 2'b10
	} bias_state_type;

endpackage

// [verilog/mic_bias_fault_diag_config.sv]
// register bank and bias power-down control for the fault monitor
// assumes fault inputs are asynchronous levels; register port is on clk_i
// Overview of operation
// - short fault turns bias off when its power-down bit is set; resets to 1
// - high-current fault turns bias off when its bit is set; resets to 0
// - low-current fault turns bias off when its bit is set; resets to 0
// - overvoltage fault turns bias off when its bit is set; resets to 0
// - overtemperature fault turns bias off when its bit is set; resets to 1
// - writing 1 to manual recovery rechecks faults and repowers if clear
// - auto-recovery bit, reset 0, lets the device recover by itself
// - short detection runs while disable bit is 0, stops when 1
// - bits 7-5 give overvoltage lower-boundary safeband, N times 30 mV
// - bits 7-5, reset 010b, give pin-to-bias upper safeband, N times 30 mV
// - bits 4-2, reset 001b, give pin overvoltage safeband; avoid codes 2-7
// - force-enable 0 auto-enables the four monitors when any input diag runs
// - individual enables of those four monitors apply only when force-enable is 1
// - analog supply monitor follows its own bit, reset 0
// - auxiliary analog monitor follows its own bit, reset 0
`timescale 1ns/100ps
`default_nettype none

module mic_bias_fault_diag_config
	import diag_cfg_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [6:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	output var  logic [7:0] reg_rdata_o,
	input  wire logic       bias_req_i,
	input  wire logic       input_diag_any_i,
	input  wire logic       fault_short_i,
	input  wire logic       fault_overcur_i,
	input  wire logic       fault_undercur_i,
	input  wire logic       fault_overvolt_i,
	input  wire logic       fault_overtemp_i,
	output logic            bias_enable_o,
	output logic            bias_fault_off_o,
	output logic            short_detect_en_o,
	output logic [2:0]      bias_ov_safeband_o,
	output logic [2:0]      pin_to_bias_safeband_o,
	output logic [2:0]      pin_ov_safeband_o,
	output logic            load_monitor_en_o,
	output logic            bias_monitor_en_o,
	output logic            battery_monitor_en_o,
	output logic            temp_monitor_en_o,
	output logic            analog_supply_monitor_en_o,
	output logic            aux_analog_monitor_en_o,
	output logic [7:0]      supply_filter_o
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	// two stages so a release near an edge cannot split the bank
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------
	// fault input synchronisers
	// ----------------------------------------
	logic [4:0] fault_raw;
	logic [4:0] fault_meta_q;
	logic [4:0] fault_q;

	assign fault_raw = {fault_short_i, fault_overcur_i, fault_undercur_i,
			fault_overvolt_i, fault_overtemp_i};

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fault_meta_q <= 5'h00;
			fault_q      <= 5'h00;
		end else begin
			fault_meta_q <= fault_raw;
			fault_q      <= fault_meta_q;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [7:0] pwrdn_q;
	logic [7:0] ov_sb_q;
	logic [7:0] in_sb_q;
	logic [7:0] mon_en_q;
	logic [7:0] filt_q;
	logic       manual_q;
	logic       manual_done;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// unmapped offsets decode to no write at all
	wire wr_pwrdn  = reg_wr_i && (reg_addr_i == PWRDN_OFFSET);
	wire wr_ov_sb  = reg_wr_i && (reg_addr_i == OV_SB_OFFSET);
	wire wr_in_sb  = reg_wr_i && (reg_addr_i == IN_SB_OFFSET);
	wire wr_mon_en = reg_wr_i && (reg_addr_i == MON_EN_OFFSET);
	wire wr_filt   = reg_wr_i && (reg_addr_i == FILT_OFFSET);
	wire manual_set = wr_pwrdn && reg_wdata_i[MANUAL_BIT];

	// reserved bits keep their reset value whatever is written
	wire [7:0] ov_sb_d  = (reg_wdata_i & OV_SB_WMASK) | (OV_SB_RESET & ~OV_SB_WMASK);
	wire [7:0] in_sb_d  = (reg_wdata_i & IN_SB_WMASK) | (IN_SB_RESET & ~IN_SB_WMASK);
	wire [7:0] mon_en_d = (reg_wdata_i & MON_EN_WMASK) | (MON_EN_RESET & ~MON_EN_WMASK);
	wire [7:0] filt_d   = (reg_wdata_i & FILT_WMASK) | (FILT_RESET & ~FILT_WMASK);

	// ----------------------------------------
	// power-down and recovery control
	// ----------------------------------------
	// bit 2 is stored but read back from the recovery flag below
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pwrdn_q <= PWRDN_RESET;
		end else if (wr_pwrdn) begin
			pwrdn_q <= reg_wdata_i;
		end
	end

	// ----------------------------------------
	// bias overvoltage safeband
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ov_sb_q <= OV_SB_RESET;
		end else if (wr_ov_sb) begin
			ov_sb_q <= ov_sb_d;
		end
	end

	// ----------------------------------------
	// input pin safebands
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			in_sb_q <= IN_SB_RESET;
		end else if (wr_in_sb) begin
			in_sb_q <= in_sb_d;
		end
	end

	// ----------------------------------------
	// monitor channel enable register
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mon_en_q <= MON_EN_RESET;
		end else if (wr_mon_en) begin
			mon_en_q <= mon_en_d;
		end
	end

	// ----------------------------------------
	// supply filter register
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			filt_q <= FILT_RESET;
		end else if (wr_filt) begin
			filt_q <= filt_d;
		end
	end

	// ----------------------------------------
	// recovery request
	// ----------------------------------------
	// self-clearing recovery request; a new write wins over completion
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q)
			manual_q <= 1'b0;
		else if (manual_set)
			manual_q <= 1'b1;
		else if (manual_done)
			manual_q <= 1'b0;
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [7:0] pwrdn_rd;

	assign pwrdn_rd = {pwrdn_q[7:3], manual_q, pwrdn_q[1:0]};

	always_comb begin
		unique case (reg_addr_i)
			PWRDN_OFFSET:  reg_rdata_o = pwrdn_rd;
			OV_SB_OFFSET:  reg_rdata_o = ov_sb_q;
			IN_SB_OFFSET:  reg_rdata_o = in_sb_q;
			MON_EN_OFFSET: reg_rdata_o = mon_en_q;
			FILT_OFFSET:   reg_rdata_o = filt_q;
			default:       reg_rdata_o = 8'h00;
		endcase
	end

	// ----------------------------------------
	// fault qualification
	// ----------------------------------------
	logic short_seen;
	logic trip;

	logic [4:0] fault_seen;
	logic [4:0] fault_arm;
	logic [4:0] fault_trip;

	assign short_detect_en_o = ~pwrdn_q[SHORT_DIS_BIT];
	assign short_seen = fault_q[4] & short_detect_en_o;
	assign fault_seen = {short_seen, fault_q[3:0]};
	assign fault_arm  = {pwrdn_q[SHORT_BIT], pwrdn_q[OVERCUR_BIT], pwrdn_q[UNDERCUR_BIT],
			pwrdn_q[OVERVOLT_BIT], pwrdn_q[OVERTEMP_BIT]};

	// ----------------------------------------
	// per-fault arming
	// ----------------------------------------
	// each kind trips only while its own power-down bit is set
	for (genvar g = 0; g < 5; g++) begin : g_fault_trip
		assign fault_trip[g] = fault_seen[g] & fault_arm[g];
	end

	assign trip = |fault_trip;

	// ----------------------------------------
	// bias power-down state machine
	// ----------------------------------------
	bias_state_type state_q;
	bias_state_type state_d;
	logic [7:0]     wait_q;
	logic [7:0]     wait_d;
	logic           recheck_end;

	// recheck waits so the fault inputs settle before judging them
	assign recheck_end = (state_q == ST_RECHECK) && (wait_q == 8'h00);
	assign manual_done = recheck_end && manual_q;

	always_comb begin
		state_d = state_q;
		wait_d  = wait_q;
		unique case (state_q)
			ST_ON: begin
				if (trip)
					state_d = ST_OFF;
			end
			ST_OFF: begin
				if (manual_q || pwrdn_q[AUTO_BIT]) begin
					state_d = ST_RECHECK;
					wait_d  = RECHECK_CYCLES - 8'h01;
				end
			end
			ST_RECHECK: begin
				if (wait_q != 8'h00)
					wait_d = wait_q - 8'h01;
				else if (trip)
					state_d = ST_OFF;
				else
					state_d = ST_ON;
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_ON;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// recheck settling counter
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wait_q <= 8'h00;
		end else begin
			wait_q <= wait_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic auto_monitors;

	assign bias_fault_off_o = (state_q != ST_ON);
	assign bias_enable_o    = bias_req_i & (state_q == ST_ON);

	// ----------------------------------------
	// safeband fields
	// ----------------------------------------
	assign bias_ov_safeband_o     = ov_sb_q[OV_SB_LSB +: 3];
	assign pin_to_bias_safeband_o = in_sb_q[PIN_BIAS_LSB +: 3];
	assign pin_ov_safeband_o      = in_sb_q[PIN_OV_LSB +: 3];

	// ----------------------------------------
	// monitor channel enables
	// ----------------------------------------
	logic [3:0] mon_own;
	logic [3:0] mon_en;

	assign mon_own = {mon_en_q[LOAD_BIT], mon_en_q[BIAS_BIT], mon_en_q[BATT_BIT],
			mon_en_q[TEMP_BIT]};

	// forced mode hands the four monitors to their own bits
	assign auto_monitors = ~mon_en_q[FORCE_BIT] & input_diag_any_i;
	for (genvar m = 0; m < 4; m++) begin : g_monitor
		assign mon_en[m] = mon_en_q[FORCE_BIT] ? mon_own[m] : auto_monitors;
	end

	assign load_monitor_en_o    = mon_en[3];
	assign bias_monitor_en_o    = mon_en[2];
	assign battery_monitor_en_o = mon_en[1];
	assign temp_monitor_en_o    = mon_en[0];

	// ----------------------------------------
	// monitors outside the force scheme
	// ----------------------------------------
	assign analog_supply_monitor_en_o = mon_en_q[AVDD_BIT];
	assign aux_analog_monitor_en_o    = mon_en_q[AUX_BIT];
	assign supply_filter_o            = filt_q;

endmodule // mic_bias_fault_diag_config

`default_nettype wire

// [test/diag_cfg_asserts.sv]
// checker for the bias fault config bank
// assumes binding to the top module ports
`timescale 1ns/100ps
`default_nettype none
module diag_cfg_asserts (
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       input_diag_any_i,
	input wire logic       bias_enable_o,
	input wire logic       bias_fault_off_o,
	input wire logic       short_detect_en_o,
	input wire logic [2:0] bias_ov_safeband_o,
	input wire logic [2:0] pin_to_bias_safeband_o,
	input wire logic [2:0] pin_ov_safeband_o,
	input wire logic       load_monitor_en_o,
	input wire logic       bias_monitor_en_o,
	input wire logic       battery_monitor_en_o,
	input wire logic       temp_monitor_en_o,
	input wire logic       analog_supply_monitor_en_o,
	input wire logic       aux_analog_monitor_en_o
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_wr(logic [6:0] a);
		reg_wr_i && reg_addr_i == a;
	endsequence
	property p_ovsb;
		s_wr(7'h51) |=> bias_ov_safeband_o == $past(reg_wdata_i[7:5]);
	endproperty
	a_ovsb: assert property (p_ovsb) else $error("ov safeband wrong");
	property p_insb;
		s_wr(7'h52) |=> {pin_to_bias_safeband_o, pin_ov_safeband_o} == $past(reg_wdata_i[7:2]);
	endproperty
	a_insb: assert property (p_insb) else $error("pin safeband wrong");
	property p_shdis;
		s_wr(7'h50) |=> short_detect_en_o == !$past(reg_wdata_i[0]);
	endproperty
	a_shdis: assert property (p_shdis) else $error("short detect wrong");
	property p_force;
		s_wr(7'h53) |=> {load_monitor_en_o, bias_monitor_en_o, battery_monitor_en_o,
			temp_monitor_en_o} == ($past(reg_wdata_i[7]) ? $past(reg_wdata_i[6:3])
			: {4{input_diag_any_i}});
	endproperty
	a_force: assert property (p_force) else $error("monitor enable wrong");
	property p_own;
		s_wr(7'h53) |=> {analog_supply_monitor_en_o, aux_analog_monitor_en_o}
			== $past(reg_wdata_i[2:1]);
	endproperty
	a_own: assert property (p_own) else $error("own enable wrong");
	property p_rsvd;
		reg_addr_i == 7'h51 |-> reg_rdata_o[4:0] == 5'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
	// recheck alone lasts far longer than eight cycles
	property p_hold;
		$rose(bias_fault_off_o) |-> bias_fault_off_o [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("bias off too short");
	property p_gate;
		bias_fault_off_o |-> !bias_enable_o;
	endproperty
	a_gate: assert property (p_gate) else $error("bias on while faulted");
endmodule // diag_cfg_asserts
bind mic_bias_fault_diag_config diag_cfg_asserts i_diag_cfg_asserts (.clk_i, .arst_n_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .input_diag_any_i, .bias_enable_o,
	.bias_fault_off_o, .short_detect_en_o, .bias_ov_safeband_o, .pin_to_bias_safeband_o,
	.pin_ov_safeband_o, .load_monitor_en_o, .bias_monitor_en_o, .battery_monitor_en_o,
	.temp_monitor_en_o, .analog_supply_monitor_en_o, .aux_analog_monitor_en_o);
`default_nettype wire

// [test/tb_mic_bias_fault_diag_config.sv]
// self-checking bench for the bias fault config bank
// assumes the package and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_mic_bias_fault_diag_config;
	logic       clk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       diag_any = 1'b0;
	logic       req = 1'b1;
	logic [7:0] filt;
	logic [4:0] flt = 5'h00;
	logic [7:0] rdata;
	logic [2:0] sb_ov, sb_pb, sb_po;
	logic [3:0] mon;
	logic       bias_en, fault_off, short_en, avdd, aux;
	int         num_errors = 0;
	int         checked = 0;
	mic_bias_fault_diag_config i_mic_bias_fault_diag_config (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata),
		.bias_req_i(req), .input_diag_any_i(diag_any), .fault_short_i(flt[0]),
		.fault_overcur_i(flt[1]), .fault_undercur_i(flt[2]), .fault_overvolt_i(flt[3]),
		.fault_overtemp_i(flt[4]), .bias_enable_o(bias_en), .bias_fault_off_o(fault_off),
		.short_detect_en_o(short_en), .bias_ov_safeband_o(sb_ov),
		.pin_to_bias_safeband_o(sb_pb), .pin_ov_safeband_o(sb_po),
		.load_monitor_en_o(mon[3]), .bias_monitor_en_o(mon[2]), .battery_monitor_en_o(mon[1]),
		.temp_monitor_en_o(mon[0]), .analog_supply_monitor_en_o(avdd),
		.aux_analog_monitor_en_o(aux), .supply_filter_o(filt));
	initial forever #12.5 clk_i = ~clk_i;
	// ----
	// helpers
	// ----
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr <= a;
		#1 check(rdata, e);
	endtask
	// bounded wait for the bias to come back
	task automatic wait_on(input int lim);
		for (int n = 0; n < lim && bias_en !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		check(8'(bias_en), 8'h01);
		if (bias_en !== 1'b1) begin
			conclude;
		end
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rd_chk(7'h50, 8'h88);
		rd_chk(7'h51, 8'h40);
		rd_chk(7'h52, 8'h44);
		rd_chk(7'h53, 8'h00);
		rd_chk(7'h55, 8'h00);
		rd_chk(7'h54, 8'h48);
		check(filt, 8'h48);
		check(8'({sb_pb, sb_po}), 8'h11);
		check(8'(bias_en), 8'h01);
		@(posedge clk_i);
		req <= 1'b0;
		@(posedge clk_i);
		#1 check(8'(bias_en), 8'h00);
		@(posedge clk_i);
		req <= 1'b1;
	endtask
	task automatic t_fields;
		wr_reg(7'h51, 8'hFF);
		rd_chk(7'h51, 8'hE0);
		check(8'(sb_ov), 8'h07);
		wr_reg(7'h52, 8'hFF);
		rd_chk(7'h52, 8'hFC);
		wr_reg(7'h55, 8'hFF);
		rd_chk(7'h51, 8'hE0);
		wr_reg(7'h53, 8'hFF);
		rd_chk(7'h53, 8'hFE);
		wr_reg(7'h54, 8'hFF);
		rd_chk(7'h54, 8'h7F);
		check(filt, 8'h7F);
	endtask
	task automatic t_mon;
		for (int i = 0; i < 4; i++) begin
			wr_reg(7'h53, i[1] ? 8'hAC : 8'h52);
			diag_any <= i[0];
			@(posedge clk_i);
			#1 check(8'({mon, avdd, aux}), i[1] ? 8'h16 : (i[0] ? 8'h3D : 8'h01));
		end
	endtask
	// each fault kind armed alone, then disarmed; short instead stays armed with short detection disabled
	task automatic t_fault;
		for (int i = 0; i < 5; i++) begin
			wr_reg(7'h50, 8'h80 >> i);
			flt <= 5'h01 << i;
			repeat (4) @(posedge clk_i);
			#1 check(8'({bias_en, fault_off}), 8'h01);
			@(posedge clk_i);
			flt <= 5'h00;
			wr_reg(7'h50, (8'h80 >> i) | 8'h04);
			rd_chk(7'h50, (8'h80 >> i) | 8'h04);
			wait_on(60);
			rd_chk(7'h50, 8'h80 >> i);
			wr_reg(7'h50, (i == 0) ? 8'h81 : 8'h00);
			#1 check(8'(short_en), (i == 0) ? 8'h00 : 8'h01);
			flt <= 5'h01 << i;
			repeat (6) @(posedge clk_i);
			#1 check(8'({bias_en, fault_off}), 8'h02);
			@(posedge clk_i);
			flt <= 5'h00;
		end
	endtask
	task automatic t_auto;
		wr_reg(7'h50, 8'h0A);
		flt <= 5'h10;
		repeat (104) @(posedge clk_i);
		#1 check(8'({bias_en, fault_off}), 8'h01);
		@(posedge clk_i);
		flt <= 5'h00;
		wait_on(100);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t_reset;
		t_fields;
		t_mon;
		t_fault;
		t_auto;
		conclude;
	end
endmodule // tb_mic_bias_fault_diag_config
`default_nettype wire
